//--- rtl/pss_pkg.sv
// constants, register map and carrier types for the sync and lock supervisor
package pss_pkg;
    // clock and sync window timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int SYNC_MIN_FREQ_KHZ = 250;
    localparam int SYNC_MAX_FREQ_KHZ = 1250;
    localparam int SYNC_MAX_FREQ_HI_KHZ = 2500;
    localparam int SYNC_MIN_PER_CYC = (1000000 / SYNC_MAX_FREQ_KHZ + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SYNC_MIN_PER_HI_CYC = (1000000 / SYNC_MAX_FREQ_HI_KHZ + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SYNC_MAX_PER_CYC = (1000000 / SYNC_MIN_FREQ_KHZ) / CLK_PERIOD_NS;
    localparam int EXT_TIMEOUT_CYC = 2 * SYNC_MAX_PER_CYC;
    localparam int VCO_MIN_PER_CYC = 64;
    localparam int PHASE_STEPS_LOG2 = 3;
    // register offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_FREQ = 8'h04;
    localparam logic [7:0] ADDR_PHASE = 8'h08;
    localparam logic [7:0] ADDR_VSTATUS = 8'h0C;
    localparam logic [7:0] ADDR_CHSTAT = 8'h10;
    localparam logic [7:0] ADDR_OVRESP = 8'h14;
    // field positions
    localparam int CTRL_RUN_LSB = 0;
    localparam int CTRL_MASK_BIT = 4;
    localparam int PHASE_CH1_LSB = 4;
    localparam int VST_LOCKED_BIT = 0;
    localparam int VST_EXT_BIT = 1;
    localparam int VST_LOCK_FAULT_BIT = 4;
    localparam int CHST_RUN_LSB = 0;
    localparam int CHST_OV_LSB = 8;
    localparam int CHST_SLAVE_LSB = 12;
    localparam int OVRESP_CH1_LSB = 8;
    // reset values
    localparam logic [15:0] FREQ_RESET = 16'h0020;
    localparam logic [1:0] RUN_RESET = 2'h0;
    localparam logic [2:0] PHASE0_RESET = 3'h0;
    localparam logic [2:0] PHASE1_RESET = 3'h4;
    localparam logic [7:0] OVRESP_RESET = 8'h00;
    localparam logic [7:0] OVRESP_HW_ONLY = 8'h00;
    localparam logic [15:0] FREQ_EXT_ONLY = 16'h0000;

    typedef enum logic [2:0] {
        PSS_OFF = 3'b001,
        PSS_RUN = 3'b010,
        PSS_FAULT = 3'b100
    } pss_state_t;

    // per-channel report from a channel unit to the supervisor
    typedef struct packed {
        logic running;
        logic start;
        logic ramp_locked;
        logic ov_set;
    } pss_ch_stat_t;

    // reference timing handed to each channel unit
    typedef struct packed {
        logic tick;
        logic [7:0] period;
    } pss_ref_t;
endpackage

//--- rtl/pss_channel.sv
// one pwm channel: phase-offset ramp, run state and slave fault handling
`timescale 1ns/1ps
module pss_channel
    import pss_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic run_en,
    input wire logic locked,
    input wire logic slave,
    input wire logic comp_high,
    input wire logic [7:0] ov_resp,
    input wire pss_ref_t ref_in,
    input wire logic [7:0] offset,
    output pss_ch_stat_t stat,
    output logic pwm
);
    pss_state_t state_reg, state_next;
    logic [7:0] cnt_reg;
    logic [7:0] ramp_cnt_reg;
    logic [7:0] ramp_per_reg;
    logic pwm_reg;

    // ramp starts at the offset after each reference tick
    wire ramp_start = (cnt_reg == offset);
    wire ramp_locked = (ramp_per_reg == ref_in.period);
    wire slave_fault = slave && comp_high;
    wire go = run_en && locked;
    wire resume = (ov_resp == OVRESP_HW_ONLY) && !comp_high && run_en && locked;

    // run state selection
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            PSS_OFF: if (go) state_next = PSS_RUN;
            PSS_RUN: if (slave_fault) state_next = PSS_FAULT; else if (!run_en) state_next = PSS_OFF;
            PSS_FAULT: if (resume) state_next = PSS_RUN; else if (!run_en && !comp_high) state_next = PSS_OFF;
            default: state_next = PSS_OFF;
        endcase
    end

    assign stat.running = (state_reg == PSS_RUN);
    assign stat.start = (state_reg == PSS_OFF) && (state_next == PSS_RUN);
    assign stat.ramp_locked = ramp_locked;
    assign stat.ov_set = (state_reg == PSS_RUN) && slave_fault;
    assign pwm = pwm_reg;

    // state and ramp counters
    always_ff @(posedge clock) begin
        if (rst) begin
            state_reg <= PSS_OFF;
            cnt_reg <= 8'h00;
            ramp_cnt_reg <= 8'h00;
            ramp_per_reg <= 8'h00;
            pwm_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= ref_in.tick ? 8'h00 : ((cnt_reg == 8'hFF) ? cnt_reg : cnt_reg + 8'h01);
            if (ramp_start) begin
                ramp_per_reg <= ramp_cnt_reg + 8'h01;
                ramp_cnt_reg <= 8'h00;
            end else if (ramp_cnt_reg != 8'hFF) begin
                ramp_cnt_reg <= ramp_cnt_reg + 8'h01;
            end
            // fault stops the output at once, half-period pulse otherwise
            pwm_reg <= (state_next == PSS_RUN) && !slave_fault && (ramp_start || (ramp_cnt_reg < (ref_in.period >> 1)));
        end
    end
endmodule

//--- rtl/pss_sync_supervisor.sv
// sync clock lock supervisor with apb registers and two pwm channels
`timescale 1ns/1ps
module pss_sync_supervisor
    import pss_pkg::*;
#(
    parameter bit HI_FREQ_VARIANT = 1'b0
)
(
    input wire logic clock,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sync_pin,
    input wire logic frequency_strap_pin,
    input wire logic [1:0] feedback_pin_slave,
    input wire logic [1:0] comp_high,
    output logic [1:0] pwm_out,
    output logic alert_out,
    output logic alert_oe
);
    // pin synchronisers
    logic sync_ff1, sync_ff2, sync_ff3;
    logic strap_ff1, strap_ff2;
    logic [1:0] slave_ff1, slave_ff2;
    logic [1:0] comp_ff1, comp_ff2;

    // sync clock measurement and lock
    logic [7:0] meas_cnt_reg;
    logic [7:0] per_reg;
    logic [7:0] prev_per_reg;
    logic seen_reg;
    logic [7:0] int_cnt_reg;
    logic locked_reg;

    // software registers
    logic [1:0] run_reg;
    logic mask_reg;
    logic [15:0] freq_reg;
    logic [2:0] phase0_reg, phase1_reg;
    logic [7:0] ovresp0_reg, ovresp1_reg;
    logic lock_fault_reg;
    logic [1:0] ov_fault_reg;
    logic strap_pending_reg;

    // bus answer
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic alert_oe_reg;
    logic alert_out_reg;

    pss_ch_stat_t st0, st1;
    logic pwm0, pwm1;

    // falling edge of the shared sync clock
    wire sync_fall = sync_ff3 && !sync_ff2;

    // external clock presence and measured period check
    wire ext_present = seen_reg && (meas_cnt_reg <= 8'(EXT_TIMEOUT_CYC));
    wire [7:0] min_per = HI_FREQ_VARIANT ? 8'(SYNC_MIN_PER_HI_CYC) : 8'(SYNC_MIN_PER_CYC);
    wire in_range = (per_reg >= min_per) && (per_reg <= 8'(SYNC_MAX_PER_CYC));
    wire [7:0] per_diff = (per_reg > prev_per_reg) ? per_reg - prev_per_reg : prev_per_reg - per_reg;
    wire per_stable = (per_diff <= 8'h01);

    // internal reference period from the frequency setting
    wire freq_zero = (freq_reg == FREQ_EXT_ONLY);
    wire [7:0] freq_per = (freq_reg[15:8] != 8'h00) ? 8'hFF : freq_reg[7:0];
    wire freq_too_slow = HI_FREQ_VARIANT && (freq_per > 8'(SYNC_MAX_PER_CYC));
    wire [7:0] set_per = freq_too_slow ? 8'(SYNC_MAX_PER_CYC) : freq_per;
    wire [7:0] int_per = freq_zero ? 8'(VCO_MIN_PER_CYC) : set_per;
    wire int_wrap = (int_cnt_reg >= int_per - 8'h01);

    // reference handed to the channels: external edge when present
    wire ref_tick = ext_present ? sync_fall : int_wrap;
    wire [7:0] ref_per = ext_present ? per_reg : int_per;
    pss_ref_t ref_bus;
    assign ref_bus.tick = ref_tick;
    assign ref_bus.period = ref_per;

    // lock indication
    wire locked_next = ext_present ? (in_range && per_stable) : !freq_zero;
    wire lock_lost = locked_reg && !locked_next;

    // phase offsets in eighths of the reference period
    // products kept at full width before the eighths are dropped
    wire [10:0] off0_prod = 11'(ref_per) * 11'(phase0_reg);
    wire [10:0] off1_prod = 11'(ref_per) * 11'(phase1_reg);
    wire [7:0] offset0 = off0_prod[10:PHASE_STEPS_LOG2];
    wire [7:0] offset1 = off1_prod[10:PHASE_STEPS_LOG2];

    // unlocked ramp at channel start
    wire ramp_bad = (st0.start && !st0.ramp_locked) || (st1.start && !st1.ramp_locked);

    // apb decode
    wire setup = psel && !penable;
    wire wr_take = psel && penable && pready_reg && pwrite;
    wire sel_ctrl = (paddr == ADDR_CTRL);
    wire sel_freq = (paddr == ADDR_FREQ);
    wire sel_phase = (paddr == ADDR_PHASE);
    wire sel_vst = (paddr == ADDR_VSTATUS);
    wire sel_chst = (paddr == ADDR_CHSTAT);
    wire sel_ovr = (paddr == ADDR_OVRESP);
    wire mapped = sel_ctrl || sel_freq || sel_phase || sel_vst || sel_chst || sel_ovr;
    wire lock_clr = wr_take && sel_vst && pwdata[VST_LOCK_FAULT_BIT];
    wire [1:0] ov_clr = (wr_take && sel_chst) ? pwdata[CHST_OV_LSB +: 2] : 2'h0;

    // read data views
    wire [31:0] rd_ctrl = {27'h0, mask_reg, 2'h0, run_reg};
    wire [31:0] rd_freq = {16'h0, freq_reg};
    wire [31:0] rd_phase = {25'h0, phase1_reg, 1'b0, phase0_reg};
    wire [31:0] rd_vst = {27'h0, lock_fault_reg, 2'h0, ext_present, locked_reg};
    wire [31:0] rd_chst = {18'h0, slave_ff2, 2'h0, ov_fault_reg, 6'h0, st1.running, st0.running};
    wire [31:0] rd_ovr = {16'h0, ovresp1_reg, ovresp0_reg};
    logic [31:0] rd_mux;
    always_comb begin
        if (sel_ctrl) begin
            rd_mux = rd_ctrl;
        end else if (sel_freq) begin
            rd_mux = rd_freq;
        end else if (sel_phase) begin
            rd_mux = rd_phase;
        end else if (sel_vst) begin
            rd_mux = rd_vst;
        end else if (sel_chst) begin
            rd_mux = rd_chst;
        end else if (sel_ovr) begin
            rd_mux = rd_ovr;
        end else begin
            rd_mux = 32'h0000_0000;
        end
    end

    // strap synchroniser runs through reset so its level is ready at release
    always_ff @(posedge clock) begin
        strap_ff1 <= frequency_strap_pin;
        strap_ff2 <= strap_ff1;
    end

    // two-flop synchronisers for the other pin inputs
    always_ff @(posedge clock) begin
        if (rst) begin
            sync_ff1 <= 1'b0;
            sync_ff2 <= 1'b0;
            sync_ff3 <= 1'b0;
            slave_ff1 <= 2'h0;
            slave_ff2 <= 2'h0;
            comp_ff1 <= 2'h0;
            comp_ff2 <= 2'h0;
        end else begin
            sync_ff1 <= sync_pin;
            sync_ff2 <= sync_ff1;
            sync_ff3 <= sync_ff2;
            slave_ff1 <= feedback_pin_slave;
            slave_ff2 <= slave_ff1;
            comp_ff1 <= comp_high;
            comp_ff2 <= comp_ff1;
        end
    end

    // period measurement between falling edges
    always_ff @(posedge clock) begin
        if (rst) begin
            meas_cnt_reg <= 8'hFF;
            per_reg <= 8'h00;
            prev_per_reg <= 8'h00;
            seen_reg <= 1'b0;
        end else if (sync_fall) begin
            meas_cnt_reg <= 8'h01;
            per_reg <= meas_cnt_reg;
            prev_per_reg <= per_reg;
            seen_reg <= 1'b1;
        end else if (meas_cnt_reg != 8'hFF) begin
            meas_cnt_reg <= meas_cnt_reg + 8'h01;
        end
    end

    // internal oscillator and lock state
    always_ff @(posedge clock) begin
        if (rst) begin
            int_cnt_reg <= 8'h00;
            locked_reg <= 1'b0;
        end else begin
            int_cnt_reg <= int_wrap ? 8'h00 : int_cnt_reg + 8'h01;
            locked_reg <= locked_next;
        end
    end

    // control registers; strap high at reset forces external clock only
    always_ff @(posedge clock) begin
        if (rst) begin
            run_reg <= RUN_RESET;
            mask_reg <= 1'b0;
            freq_reg <= FREQ_RESET;
            phase0_reg <= PHASE0_RESET;
            phase1_reg <= PHASE1_RESET;
            ovresp0_reg <= OVRESP_RESET;
            ovresp1_reg <= OVRESP_RESET;
            strap_pending_reg <= 1'b1;
        end else begin
            strap_pending_reg <= 1'b0;
            if (strap_pending_reg && strap_ff2) begin
                freq_reg <= FREQ_EXT_ONLY;
            end else if (wr_take && sel_freq) begin
                freq_reg <= pwdata[15:0];
            end
            if (wr_take && sel_ctrl) begin
                run_reg <= pwdata[CTRL_RUN_LSB +: 2];
                mask_reg <= pwdata[CTRL_MASK_BIT];
            end
            if (wr_take && sel_phase) begin
                phase0_reg <= pwdata[2:0];
                phase1_reg <= pwdata[PHASE_CH1_LSB +: 3];
            end
            if (wr_take && sel_ovr) begin
                ovresp0_reg <= pwdata[7:0];
                ovresp1_reg <= pwdata[OVRESP_CH1_LSB +: 8];
            end
        end
    end

    // sticky faults: a new event wins over a clear in the same cycle
    always_ff @(posedge clock) begin
        if (rst) begin
            lock_fault_reg <= 1'b0;
            ov_fault_reg <= 2'h0;
        end else begin
            lock_fault_reg <= lock_lost || ramp_bad || (lock_fault_reg && !lock_clr);
            ov_fault_reg <= {st1.ov_set, st0.ov_set} | (ov_fault_reg & ~ov_clr);
        end
    end

    // alert line pulled low while an unmasked lock fault stands
    always_ff @(posedge clock) begin
        if (rst) begin
            alert_oe_reg <= 1'b0;
            alert_out_reg <= 1'b0;
        end else begin
            alert_oe_reg <= lock_fault_reg && !mask_reg;
            alert_out_reg <= 1'b0;
        end
    end

    // apb answer: zero wait states, unmapped offsets give pslverr
    always_ff @(posedge clock) begin
        if (rst) begin
            prdata_reg <= 32'h0000_0000;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end else if (setup) begin
            prdata_reg <= pwrite ? 32'h0000_0000 : rd_mux;
            pready_reg <= 1'b1;
            pslverr_reg <= !mapped;
        end else begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end
    end

    // the two pwm channels
    pss_channel u_ch0 (
        .clock(clock),
        .rst(rst),
        .run_en(run_reg[0]),
        .locked(locked_reg),
        .slave(slave_ff2[0]),
        .comp_high(comp_ff2[0]),
        .ov_resp(ovresp0_reg),
        .ref_in(ref_bus),
        .offset(offset0),
        .stat(st0),
        .pwm(pwm0)
    );

    pss_channel u_ch1 (
        .clock(clock),
        .rst(rst),
        .run_en(run_reg[1]),
        .locked(locked_reg),
        .slave(slave_ff2[1]),
        .comp_high(comp_ff2[1]),
        .ov_resp(ovresp1_reg),
        .ref_in(ref_bus),
        .offset(offset1),
        .stat(st1),
        .pwm(pwm1)
    );

    // outputs
    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign alert_oe = alert_oe_reg;
    assign alert_out = alert_out_reg;
    assign pwm_out = {pwm1, pwm0};
endmodule

//--- tb/pss_sync_supervisor_props.sv
// port-level assertions for the sync and lock supervisor
`timescale 1ns/1ps
module pss_sync_supervisor_props
    import pss_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic sync_pin,
    input wire logic frequency_strap_pin,
    input wire logic [1:0] feedback_pin_slave,
    input wire logic [1:0] comp_high,
    input wire logic [1:0] pwm_out,
    input wire logic alert_out,
    input wire logic alert_oe
);
    logic mask_reg;
    logic zero_reg;
    logic ext_reg;
    logic sync_reg;
    // register writes and falling sync edges seen from the pins
    wire wr_done = psel && penable && pready && pwrite;
    wire sync_fall = sync_reg && !sync_pin;

    // shadow of the alert mask, the external-only setting and sync activity
    always_ff @(posedge clock) begin
        sync_reg <= sync_pin;
        if (rst) begin
            mask_reg <= 1'b0;
            zero_reg <= frequency_strap_pin;
            ext_reg <= 1'b0;
        end else begin
            if (wr_done && paddr == ADDR_CTRL) mask_reg <= pwdata[CTRL_MASK_BIT];
            if (wr_done && paddr == ADDR_FREQ) zero_reg <= (pwdata[15:0] == FREQ_EXT_ONLY);
            if (sync_fall) ext_reg <= 1'b1;
        end
    end

    default clocking @(posedge clock); endclocking
    default disable iff (rst);

    sequence setup_s;
        psel && !penable;
    endsequence
    sequence slave_fault_s(int i);
        (feedback_pin_slave[i] && comp_high[i]) [*6];
    endsequence

    ready_after_setup_a: assert property (setup_s |=> pready) else $error("no ready after setup");
    ready_pulse_a: assert property (pready |=> !pready) else $error("ready longer than one cycle");
    err_with_ready_a: assert property (pslverr |-> pready) else $error("error without ready");
    err_unmapped_a: assert property (pready && paddr > ADDR_OVRESP |-> pslverr) else $error("unmapped not refused");
    alert_level_a: assert property (!alert_out) else $error("alert line driven high");
    mask_hold_a: assert property (mask_reg [*2] |-> !alert_oe) else $error("masked alert asserted");
    ext_only_a: assert property (zero_reg && !ext_reg |-> pwm_out == 2'h0) else $error("pwm without clock");
    reset_quiet_a: assert property ($fell(rst) |-> pwm_out == 2'h0 && !alert_oe) else $error("output after reset");
    slave0_stop_a: assert property (slave_fault_s(0) |-> !pwm_out[0]) else $error("slave 0 kept pwm");
    slave1_stop_a: assert property (slave_fault_s(1) |-> !pwm_out[1]) else $error("slave 1 kept pwm");
endmodule

bind pss_sync_supervisor pss_sync_supervisor_props chk (.clock, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .sync_pin, .frequency_strap_pin, .feedback_pin_slave, .comp_high, .pwm_out,
    .alert_out, .alert_oe);

//--- tb/pss_sync_peer.sv
// peer controller that drives the shared sync clock
`timescale 1ns/1ps
module pss_sync_peer #(
    parameter int HALF_NS = 400
)
(
    input wire logic enable,
    output logic sync_out
);
    // only this peer drives the line; it rests high between bursts
    initial begin
        sync_out = 1'b1;
        #137;
        forever begin
            if (enable) begin
                #HALF_NS sync_out = 1'b0;
                #HALF_NS sync_out = 1'b1;
            end else begin
                #HALF_NS;
            end
        end
    end
endmodule

//--- tb/pss_sync_supervisor_bench.sv
// self-checking bench for the sync and lock supervisor
`timescale 1ns/1ps
module pss_sync_supervisor_bench;
    import pss_pkg::*;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic sync_pin;
    logic strap = 1'b0;
    logic [1:0] slave = 2'h0;
    logic [1:0] comp = 2'h0;
    logic [1:0] pwm_out;
    logic alert_out;
    logic alert_oe;
    logic [1:0] pwm_hi;
    wire [3:0] pwm_all = {pwm_hi, pwm_out};
    logic peer_en = 1'b0;
    logic err;
    logic [31:0] q;
    int n_mismatch = 0;
    int cmp_count = 0;
    int cyc = 0;
    int ta;
    int tb;
    int p0;
    int p1;
    int f;

    pss_sync_supervisor uut (.clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sync_pin(sync_pin), .frequency_strap_pin(strap), .feedback_pin_slave(slave), .comp_high(comp),
        .pwm_out(pwm_out), .alert_out(alert_out), .alert_oe(alert_oe));
    pss_sync_peer peer (.enable(peer_en), .sync_out(sync_pin));
    // fast variant shares the bus and pins; only its pwm is watched
    pss_sync_supervisor #(.HI_FREQ_VARIANT(1'b1)) uut_hi (.clock(clock), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(), .pready(), .pslverr(),
        .sync_pin(sync_pin), .frequency_strap_pin(strap), .feedback_pin_slave(slave), .comp_high(comp),
        .pwm_out(pwm_hi), .alert_out(), .alert_oe());

    // bench clock and cycle count
    initial forever #50 clock = ~clock;
    always @(posedge clock) cyc <= cyc + 1;

    task automatic results;
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // one apb transfer; read data and error land in q and err
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1 && n < 20) begin
            n++;
            @(posedge clock);
        end
        if (n >= 20) check(1, 0);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // cycle of the next rising edge on one pwm output
    task automatic rise(input int ch, output int t);
        int n;
        logic prev;
        n = 0;
        t = 0;
        prev = 1'b1;
        while (n < 400 && t == 0) begin
            @(posedge clock);
            if (prev === 1'b0 && pwm_all[ch] === 1'b1) t = cyc;
            prev = pwm_all[ch];
            n++;
        end
        if (t == 0) check(1, 0);
    endtask

    task automatic reset_dut(input logic s);
        strap <= s;
        rst <= 1'b1;
        repeat (10) @(posedge clock);
        rst <= 1'b0;
    endtask

    function automatic int exp_gap(input int a, input int b, input int per);
        return ((b - a) & 7) * per / 8;
    endfunction

    // hang guard
    initial begin
        #3000000;
        n_mismatch++;
        results();
    end

    // main sequence
    initial begin
        f = $urandom(32'h5bcf);
        reset_dut(1'b0);
        apb(0, ADDR_CTRL, 0);
        check(q, 0);
        apb(0, ADDR_FREQ, 0);
        check(q, FREQ_RESET);
        apb(0, ADDR_PHASE, 0);
        check(q, 32'h0000_0040);
        apb(0, ADDR_CHSTAT, 0);
        check(q, 0);
        apb(0, ADDR_OVRESP, 0);
        check(q, OVRESP_RESET);
        apb(0, 8'h18, 0);
        check(err, 1);
        check(q, 0);
        f = 8 + $urandom % 33;
        apb(1, ADDR_FREQ, f);
        apb(1, ADDR_CTRL, 1);
        rise(0, ta);
        rise(0, ta);
        rise(0, tb);
        check(tb - ta, f);
        apb(1, ADDR_FREQ, 32'h0000_00C8);
        rise(2, ta);
        rise(2, ta);
        rise(2, tb);
        check(tb - ta, SYNC_MAX_PER_CYC);
        reset_dut(1'b1);
        apb(0, ADDR_FREQ, 0);
        check(q, 0);
        apb(1, ADDR_CTRL, 3);
        repeat (150) @(posedge clock);
        check(pwm_out, 0);
        apb(0, ADDR_VSTATUS, 0);
        check(q[1:0], 0);
        peer_en <= 1'b1;
        repeat (60) @(posedge clock);
        apb(0, ADDR_VSTATUS, 0);
        check(q[1:0], 3);
        apb(1, ADDR_VSTATUS, 32'h0000_0010);
        for (int i = 0; i < 4; i++) begin
            p0 = $urandom % 8;
            p1 = $urandom % 8;
            apb(1, ADDR_PHASE, (p1 << 4) | p0);
            rise(0, ta);
            rise(0, ta);
            rise(1, tb);
            check((tb - ta) % 8, exp_gap(p0, p1, 8));
        end
        peer_en <= 1'b0;
        repeat (150) @(posedge clock);
        apb(0, ADDR_VSTATUS, 0);
        check(q[4:0], 5'h10);
        check(alert_oe, 1);
        rise(0, ta);
        rise(0, tb);
        check(tb - ta, VCO_MIN_PER_CYC);
        apb(1, ADDR_VSTATUS, 0);
        apb(0, ADDR_VSTATUS, 0);
        check(q[4], 1);
        peer_en <= 1'b1;
        repeat (60) @(posedge clock);
        apb(0, ADDR_VSTATUS, 0);
        check(q[4], 1);
        apb(1, ADDR_VSTATUS, 32'h0000_0010);
        apb(0, ADDR_VSTATUS, 0);
        check(q[4], 0);
        repeat (3) @(posedge clock);
        check(alert_oe, 0);
        apb(1, ADDR_CTRL, 32'h0000_0013);
        peer_en <= 1'b0;
        repeat (150) @(posedge clock);
        check(alert_oe, 0);
        peer_en <= 1'b1;
        repeat (60) @(posedge clock);
        apb(1, ADDR_VSTATUS, 32'h0000_0010);
        apb(1, ADDR_CTRL, 3);
        slave <= 2'h1;
        comp <= 2'h1;
        repeat (10) @(posedge clock);
        check(pwm_out[0], 0);
        apb(0, ADDR_CHSTAT, 0);
        check(q[12], 1);
        check(q[8], 1);
        comp <= 2'h0;
        rise(0, ta);
        apb(1, ADDR_CHSTAT, 32'h0000_0100);
        apb(0, ADDR_CHSTAT, 0);
        check(q[8], 0);
        apb(1, ADDR_OVRESP, 32'h0000_8080);
        comp <= 2'h1;
        repeat (10) @(posedge clock);
        comp <= 2'h0;
        repeat (10) @(posedge clock);
        check(pwm_out[0], 0);
        apb(0, ADDR_CHSTAT, 0);
        check(q[9:8], 2'h1);
        check(q[1:0], 2'h2);
        apb(1, ADDR_CTRL, 2);
        apb(1, ADDR_CTRL, 3);
        apb(0, ADDR_CHSTAT, 0);
        check(q[1:0], 2'h3);
        results();
    end
endmodule
